/* bmf_top.sv */
/*
 level detector, nco and mixer, rrc fir and integrate-and-dump of the i/q path.
 assumes the tuner drives samples on clk and config ports change rarely.
*/
`timescale 1ns/1ps
`include "bmf_defines.svh"
module bmf_top #(
	parameter int BUF_DEPTH = 2, // output buffer entries
	parameter int TAPS = `BMF_RRC_TAPS // rrc length
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst_n, // sync reset
	input wire logic [9:0] sampleI, // raw i sample
	input wire logic [9:0] sampleQ, // raw q sample
	input wire logic sampleEnable_n, // sample qualifier
	output logic sampleReady, // pipeline advances
	input wire logic [31:0] dataPathCfg, // path config word
	input wire logic [7:0] loopCtl1, // carrier loop control
	input wire bmf_pkg::bmf_word_t loopUpper, // upper limit
	input wire bmf_pkg::bmf_word_t loopLower, // lower limit
	input wire bmf_pkg::bmf_word_t loopLead, // lead term
	input wire bmf_pkg::bmf_word_t loopLag, // lag term
	input wire logic loopUpdate, // loop output strobe
	output logic levelCompareOut, // level detector
	output bmf_pkg::bmf_word_t carrierFreqWord, // nco word
	output bmf_pkg::bmf_word_t extNcoWord, // term for outside nco
	output bmf_pkg::bmf_sample_t outI, // interleaved i
	output bmf_pkg::bmf_sample_t outQ, // interleaved q
	output logic outMid, // mid-symbol sample
	output logic outValid, // buffer not empty
	input wire logic outReady, // receiver takes word
	output bmf_pkg::bmf_sample_t symEndI, // end stream i
	output bmf_pkg::bmf_sample_t symEndQ, // end stream q
	output bmf_pkg::bmf_sample_t symMidI, // mid stream i
	output bmf_pkg::bmf_sample_t symMidQ, // mid stream q
	output logic symStrobe // symbol pair done
);
	import bmf_pkg::*;

	if (BUF_DEPTH != 2) $error("BUF_DEPTH must be 2");
	if (TAPS != `BMF_RRC_TAPS) $error("TAPS must be 15");

	function automatic bmf_sample_t sat(input logic signed [14:0] v);
		if (v > 15'sd511)
			return 10'sh1ff;
		if (v < -15'sd512)
			return 10'sh200;
		return v[9:0];
	endfunction

	function automatic logic [9:0] absv(input bmf_sample_t x);
		return x[9] ? 10'(-x) : 10'(x);
	endfunction

	// quarter wave, half-step offset, amplitude 127
	function automatic logic signed [7:0] sinLut(input logic [5:0] p);
		logic [3:0] idx;
		logic [6:0] mag;
		idx = p[4] ? ~p[3:0] : p[3:0];
		case (idx)
			4'h0: mag = 7'h06;
			4'h1: mag = 7'h13;
			4'h2: mag = 7'h1f;
			4'h3: mag = 7'h2b;
			4'h4: mag = 7'h36;
			4'h5: mag = 7'h41;
			4'h6: mag = 7'h4c;
			4'h7: mag = 7'h55;
			4'h8: mag = 7'h5e;
			4'h9: mag = 7'h66;
			4'ha: mag = 7'h6d;
			4'hb: mag = 7'h73;
			4'hc: mag = 7'h78;
			4'hd: mag = 7'h7b;
			4'he: mag = 7'h7e;
			default: mag = 7'h7f;
		endcase
		return p[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction

	function automatic logic signed [8:0] rrcCoef(input int k);
		case (k)
			0, 14: return 9'sh002;
			1, 13: return -9'sh002;
			2, 12: return 9'sh001;
			3, 11: return 9'sh008;
			4, 10: return -9'sh010;
			5, 9: return -9'sh00e;
			6, 8: return 9'sh056;
			default: return 9'sh0a0;
		endcase
	endfunction

	logic adv, v0_r, v1_r, v2_r, v3_r, v4_r, mid4_r, levelOver, pop;
	logic rrcOn, iadOn, offBin, sense, bypassNco, extNco, leadOnly;
	logic [2:0] decCode, decEff, shAmt;
	logic [3:0] nMinus1, iadCnt_r;
	logic [10:0] magEst;
	logic [9:0] big, smallAbs;
	bmf_filt_e filtMode;
	bmf_sample_t x0_r [2];
	bmf_sample_t x1_r [2];
	bmf_sample_t x2 [2];
	bmf_sample_t d3_r [2];
	bmf_sample_t prev_r [2];
	bmf_sample_t s4_r [2];
	bmf_sample_t tap_r [2][TAPS];
	logic signed [19:0] rrcAcc [2];
	logic signed [13:0] iadAcc_r [2];
	logic signed [13:0] iadSum [2];
	logic signed [18:0] mixI, mixQ;
	logic signed [7:0] cosV, sinV;
	logic signed [32:0] cSum, want;
	bmf_word_t phase_r, center;
	logic [20:0] bufMem_r [BUF_DEPTH];
	logic wp_r, rp_r;
	logic [1:0] bufCnt_r;

	assign rrcOn = dataPathCfg[`BMF_CFG_RRC_ON];
	assign decCode = dataPathCfg[`BMF_CFG_DEC_MSB:`BMF_CFG_DEC_LSB];
	assign decEff = (decCode > `BMF_DEC_MAX_CODE) ? `BMF_DEC_MAX_CODE : decCode;
	assign iadOn = (decCode != 3'h0);
	assign shAmt = dataPathCfg[`BMF_CFG_SHIFT_MSB:`BMF_CFG_SHIFT_LSB];
	assign filtMode = bmf_filt_e'({iadOn, rrcOn});
	assign offBin = dataPathCfg[`BMF_CFG_OFFSET_BIN];
	assign sense = dataPathCfg[`BMF_CFG_SENSE];
	assign bypassNco = dataPathCfg[`BMF_CFG_NCO_BYPASS];
	assign extNco = loopCtl1[`BMF_LF1_EXT_NCO];
	assign leadOnly = loopCtl1[`BMF_LF1_LEAD_ONLY];
	assign adv = (bufCnt_r != 2'(BUF_DEPTH));
	assign sampleReady = adv;

	// input capture, serial mode is handled elsewhere
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			v0_r <= 1'b0;
			x0_r <= '{default: '0};
		end
		else if (adv)
		begin
			v0_r <= !sampleEnable_n;
			x0_r[0] <= {sampleI[9] ^ offBin, sampleI[8:0]};
			x0_r[1] <= {sampleQ[9] ^ offBin, sampleQ[8:0]};
		end
	end

	always_comb
	begin
		big = (absv(x0_r[0]) >= absv(x0_r[1])) ? absv(x0_r[0]) : absv(x0_r[1]);
		smallAbs = (absv(x0_r[0]) >= absv(x0_r[1])) ? absv(x0_r[1]) : absv(x0_r[0]);
		magEst = 11'(big) + 11'(smallAbs >> 2) + 11'(smallAbs >> 3);
		levelOver = magEst > {1'b0, dataPathCfg[`BMF_CFG_THR_MSB:`BMF_CFG_THR_LSB], 2'b00};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			levelCompareOut <= `BMF_RST_LEVEL;
		else if (v0_r && adv)
			levelCompareOut <= !(levelOver ^ sense);
	end

	// frequency word: centre plus loop terms, held inside the limits
	always_comb
	begin
		cSum = $signed({loopUpper[31], loopUpper}) + $signed({loopLower[31], loopLower});
		center = cSum[32:1];
		want = $signed({center[31], center});
		if (!extNco)
			want = want + $signed({loopLead[31], loopLead});
		if (!extNco && !leadOnly)
			want = want + $signed({loopLag[31], loopLag});
		if (want > $signed({loopUpper[31], loopUpper}))
			want = $signed({loopUpper[31], loopUpper});
		if (want < $signed({loopLower[31], loopLower}))
			want = $signed({loopLower[31], loopLower});
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			carrierFreqWord <= `BMF_RST_WORD;
			extNcoWord <= `BMF_RST_WORD;
		end
		else if (loopUpdate)
		begin
			carrierFreqWord <= want[31:0];
			extNcoWord <= extNco ? loopLead + loopLag : (leadOnly ? loopLag : `BMF_RST_WORD);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			phase_r <= `BMF_RST_WORD;
		else
			phase_r <= phase_r + carrierFreqWord;
	end

	assign sinV = sinLut(phase_r[31:26]);
	assign cosV = sinLut(phase_r[31:26] + 6'h10);
	assign mixI = 19'(x0_r[0] * cosV) - 19'(x0_r[1] * sinV);
	assign mixQ = 19'(x0_r[0] * sinV) + 19'(x0_r[1] * cosV);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			v1_r <= 1'b0;
			x1_r <= '{default: '0};
		end
		else if (adv)
		begin
			v1_r <= v0_r;
			x1_r[0] <= bypassNco ? x0_r[0] : sat(15'(mixI >>> `BMF_MIX_SHIFT));
			x1_r[1] <= bypassNco ? x0_r[1] : sat(15'(mixQ >>> `BMF_MIX_SHIFT));
		end
	end

	// rrc delay line, newest sample in tap 0
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			v2_r <= 1'b0;
			tap_r <= '{default: '{default: '0}};
		end
		else if (adv)
		begin
			v2_r <= v1_r;
			if (v1_r)
			begin
				for (int c = 0; c < 2; c++)
				begin
					tap_r[c][0] <= x1_r[c];
					for (int k = 1; k < TAPS; k++)
						tap_r[c][k] <= tap_r[c][k-1];
				end
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			rrcAcc[c] = '0;
			for (int k = 0; k < TAPS; k++)
				rrcAcc[c] = rrcAcc[c] + 20'(tap_r[c][k] * rrcCoef(k));
			x2[c] = (filtMode == BMF_FILT_RRC || filtMode == BMF_FILT_BOTH) ?
				sat(15'(rrcAcc[c] >>> `BMF_RRC_SHIFT)) : tap_r[c][0];
			iadSum[c] = (iadCnt_r == 4'h0 ? 14'sh0000 : iadAcc_r[c]) + 14'(x2[c]);
		end
		nMinus1 = 4'((5'h01 << (decEff - 3'h1)) - 5'h01);
	end

	// integrate and dump, one dump per nMinus1+1 samples
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			v3_r <= 1'b0;
			iadCnt_r <= 4'h0;
			iadAcc_r <= '{default: '0};
			d3_r <= '{default: '0};
		end
		else if (adv)
		begin
			v3_r <= 1'b0;
			if (v2_r && !iadOn)
			begin
				v3_r <= 1'b1;
				d3_r <= x2;
			end
			else if (v2_r && iadCnt_r >= nMinus1)
			begin
				v3_r <= 1'b1;
				iadCnt_r <= 4'h0;
				for (int c = 0; c < 2; c++)
					d3_r[c] <= sat(15'(iadSum[c] >>> shAmt));
			end
			else if (v2_r)
			begin
				iadCnt_r <= iadCnt_r + 4'h1;
				iadAcc_r <= iadSum;
			end
		end
	end

	// two-sample summer and end/mid marking
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			v4_r <= 1'b0;
			mid4_r <= 1'b1;
			prev_r <= '{default: '0};
			s4_r <= '{default: '0};
		end
		else if (adv)
		begin
			v4_r <= v3_r;
			if (v3_r)
			begin
				mid4_r <= !mid4_r;
				prev_r <= d3_r;
				for (int c = 0; c < 2; c++)
					s4_r[c] <= iadOn ? sat(15'(d3_r[c]) + 15'(prev_r[c])) : d3_r[c];
			end
		end
	end

	// two-entry output buffer, full stalls every stage but the nco phase accumulator
	assign pop = outValid && outReady;
	assign outValid = (bufCnt_r != 2'h0);
	assign {outMid, outI, outQ} = bufMem_r[rp_r];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			bufCnt_r <= 2'h0;
			bufMem_r <= '{default: '0};
		end
		else
		begin
			if (v4_r && adv)
			begin
				// mid4_r already flipped for this word: end first after reset
				bufMem_r[wp_r] <= {mid4_r, s4_r[0], s4_r[1]};
				wp_r <= !wp_r;
			end
			if (pop)
				rp_r <= !rp_r;
			bufCnt_r <= bufCnt_r + 2'(v4_r && adv) - 2'(pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			symStrobe <= 1'b0;
			{symEndI, symEndQ, symMidI, symMidQ} <= '0;
		end
		else
		begin
			symStrobe <= pop && outMid;
			if (pop && outMid)
				{symMidI, symMidQ} <= {outI, outQ};
			if (pop && !outMid)
				{symEndI, symEndQ} <= {outI, outQ};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sTake;
		adv && !sampleEnable_n;
	endsequence
	sequence sDumpDue;
		adv && v2_r && iadOn && iadCnt_r == nMinus1;
	endsequence

	AST_ENABLE_IN: assert property (sTake |=> v0_r) else $error("sample lost");
	AST_ENABLE_OUT: assert property (adv && sampleEnable_n |=> !v0_r)
		else $error("sample taken with enable high");
	AST_NCO_STEP: assert property (##1 phase_r == $past(phase_r) + $past(carrierFreqWord))
		else $error("phase step wrong");
	AST_LEVEL: assert property (v0_r && adv |=> levelCompareOut == ($past(levelOver) == $past(sense)))
		else $error("level output wrong");
	AST_BYPASS: assert property (v0_r && adv && bypassNco |=> x1_r[0] == $past(x0_r[0]))
		else $error("mixer bypass wrong");
	AST_FIXED_FREQ: assert property (loopUpdate && loopUpper == loopLower
		|=> carrierFreqWord == $past(loopUpper)) else $error("nco not fixed");
	AST_DUMP: assert property (sDumpDue |=> v3_r ##1 (!$past(adv) || v4_r))
		else $error("dump missing");
	AST_NO_DUMP: assert property (adv && v2_r && iadOn && iadCnt_r < nMinus1 |=> !v3_r)
		else $error("early dump");
	AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outI))
		else $error("buffer dropped word");
	AST_SPLIT: assert property (pop && outMid |=> symStrobe && symMidI == $past(outI))
		else $error("split stream wrong");
endmodule

/* bmf_defines.svh */
/*
 constants of the baseband mixer and matched filter block.
 assumes inclusion by bare name from any file that needs them.
*/
`ifndef BMF_DEFINES_SVH
`define BMF_DEFINES_SVH
`define BMF_CFG_RRC_ON 1
`define BMF_CFG_DEC_LSB 2
`define BMF_CFG_DEC_MSB 4
`define BMF_CFG_SHIFT_LSB 5
`define BMF_CFG_SHIFT_MSB 7
`define BMF_CFG_NCO_BYPASS 10
`define BMF_CFG_SENSE 13
`define BMF_CFG_OFFSET_BIN 14
`define BMF_CFG_SERIAL 15
`define BMF_CFG_THR_LSB 16
`define BMF_CFG_THR_MSB 23
`define BMF_LF1_LEAD_ONLY 5
`define BMF_LF1_EXT_NCO 6
`define BMF_DEC_MAX_CODE 3'h5
`define BMF_RRC_TAPS 15
`define BMF_RRC_SHIFT 8
`define BMF_MIX_SHIFT 7
`define BMF_RST_WORD 32'h0000_0000
`define BMF_RST_LEVEL 1'b0
`endif

/* bmf_pkg.sv */
/*
 types shared by the baseband mixer and matched filter block.
 assumes nothing of its surroundings.
*/
package bmf_pkg;
	typedef logic signed [9:0] bmf_sample_t;
	typedef logic [31:0] bmf_word_t;
	typedef enum logic [1:0] {BMF_FILT_NONE, BMF_FILT_RRC, BMF_FILT_IAD, BMF_FILT_BOTH} bmf_filt_e;
endpackage

/* bmf_tuner_model.sv */
/*
 upstream tuner model: offers one i/q sample at a time.
 assumes the bench calls its tasks; lines change on the falling edge.
*/
`timescale 1ns/1ps
module bmf_tuner_model (
	input wire logic clk, // system clock
	input wire logic sampleReady, // pipeline advances
	output logic [9:0] sampleI, // i sample
	output logic [9:0] sampleQ, // q sample
	output logic sampleEnable_n // sample qualifier
);
	initial
	begin
		sampleI = 10'h000;
		sampleQ = 10'h000;
		sampleEnable_n = 1'b1;
	end
	// hold the sample until an edge with ready high takes it
	task send(input logic [9:0] i, input logic [9:0] q);
		@(negedge clk);
		sampleI = i;
		sampleQ = q;
		sampleEnable_n = 1'b0;
		#1;
		while (sampleReady !== 1'b1)
		begin
			@(negedge clk);
			#1;
		end
		@(posedge clk);
	endtask
	// released data lines show the inverse of the last value
	task idle();
		@(negedge clk);
		sampleEnable_n = 1'b1;
		sampleI = ~sampleI;
		sampleQ = ~sampleQ;
	endtask
endmodule

/* tb.sv */
/*
 self-checking bench of the mixer and matched filter block.
 assumes the design files and the tuner model are compiled first.
*/
`timescale 1ns/1ps
module tb;
	import bmf_pkg::*;
	logic clk, rst_n, sampleEnable_n, sampleReady, loopUpdate, levelCompareOut;
	logic outMid, outValid, outReady, stall, expMid, symStrobe, popSeen;
	bmf_sample_t symEndI, symEndQ, symMidI, symMidQ;
	logic [20:0] lastExp;
	logic [9:0] sampleI, sampleQ;
	logic [31:0] dataPathCfg;
	logic [7:0] loopCtl1;
	bmf_word_t loopUpper, loopLower, loopLead, loopLag, carrierFreqWord, extNcoWord;
	bmf_sample_t outI, outQ;
	logic [19:0] expQ[$];
	logic [15:0] lfsr;
	int errCount, checks, cyc, n;
	int coef[15] = '{2, -2, 1, 8, -16, -14, 86, 160, 86, -14, -16, 8, 1, -2, 2};
	logic [9:0] lvI[5] = '{10'h064, 10'h064, 10'h3c4, 10'h3c4, 10'h050};
	logic [9:0] lvQ[5] = '{10'h000, 10'h000, 10'h050, 10'h050, 10'h3c4};
	logic [7:0] lvT[5] = '{8'd20, 8'd30, 8'd24, 8'd26, 8'd24};
	logic lvS[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic lvE[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	int lpU[6] = '{3000, 3000, 3000, 3000, 3000, -1234};
	int lpL[6] = '{1000, 1000, 1000, 1000, 1000, -1234};
	int lpD[6] = '{100, 100, 100, 5000, -5000, 0};
	int lpG[6] = '{10, 10, 10, 0, 0, 77};
	int lpC[6] = '{0, 32, 64, 0, 0, 0};
	int lpW[6] = '{2110, 2100, 2000, 3000, 1000, -1234};
	int lpE[6] = '{0, 10, 110, 0, 0, 0};
	bmf_top u_dut (.clk(clk), .rst_n(rst_n), .sampleI(sampleI), .sampleQ(sampleQ),
		.sampleEnable_n(sampleEnable_n), .sampleReady(sampleReady),
		.dataPathCfg(dataPathCfg), .loopCtl1(loopCtl1), .loopUpper(loopUpper),
		.loopLower(loopLower), .loopLead(loopLead), .loopLag(loopLag),
		.loopUpdate(loopUpdate), .levelCompareOut(levelCompareOut),
		.carrierFreqWord(carrierFreqWord), .extNcoWord(extNcoWord), .outI(outI),
		.outQ(outQ), .outMid(outMid), .outValid(outValid), .outReady(outReady),
		.symEndI(symEndI), .symEndQ(symEndQ), .symMidI(symMidI), .symMidQ(symMidQ),
		.symStrobe(symStrobe));
	bmf_tuner_model u_tun (.clk(clk), .sampleReady(sampleReady), .sampleI(sampleI),
		.sampleQ(sampleQ), .sampleEnable_n(sampleEnable_n));
	function automatic logic [15:0] nextLfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			errCount++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task finishTest();
		$display("checks %0d errors %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task doReset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		expMid = 1'b0;
		rst_n = 1'b1;
	endtask
	task sx(input logic [9:0] i, input logic [9:0] q, input logic [9:0] ei,
		input logic [9:0] eq);
		expQ.push_back({ei, eq});
		u_tun.send(i, q);
	endtask
	task drain();
		u_tun.idle();
		repeat (300)
			if (expQ.size() != 0)
				@(negedge clk);
		check(32'(expQ.size()), 32'h0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errCount++;
			$display("mismatch at %0t: timeout", $time);
			finishTest();
		end
	end
	// random receiver stall while enabled
	always @(negedge clk)
	begin
		lfsr <= nextLfsr(lfsr);
		outReady <= stall ? lfsr[0] : 1'b1;
	end
	always @(posedge clk)
	begin
		if (popSeen === 1'b1)
		begin
			check(symStrobe, lastExp[20]);
			check(lastExp[20] ? {symMidI, symMidQ} : {symEndI, symEndQ}, lastExp[19:0]);
		end
		popSeen = 1'b0;
		if (outValid === 1'b1 && outReady === 1'b1)
		begin
			if (expQ.size() == 0)
				check(32'h1, 32'h0);
			else
			begin
				lastExp = {expMid, expQ.pop_front()};
				check({outMid, outI, outQ}, lastExp);
				popSeen = 1'b1;
			end
			expMid = ~expMid;
		end
	end
	initial
	begin
		rst_n = 1'b0;
		outReady = 1'b1;
		stall = 1'b0;
		expMid = 1'b0;
		popSeen = 1'b0;
		lfsr = 16'h0058;
		loopUpdate = 1'b0;
		loopCtl1 = 8'h00;
		{loopUpper, loopLower, loopLead, loopLag} = 128'h0;
		dataPathCfg = 32'h0;
		doReset();
		check({outValid, sampleReady, levelCompareOut}, 3'b010);
		check(carrierFreqWord, 32'h0);
		sx(10'h080, 10'h300, 10'h08b, 10'h308);
		sx(10'h380, 10'h040, 10'h37e, 10'h039);
		drain();
		for (n = 0; n < 5; n++)
		begin
			dataPathCfg = {8'h00, lvT[n], 2'b00, lvS[n], 2'b00, 1'b1, 10'h000};
			sx(lvI[n], lvQ[n], lvI[n], lvQ[n]);
			u_tun.idle();
			@(negedge clk);
			check(levelCompareOut, lvE[n]);
		end
		drain();
		stall = 1'b1;
		dataPathCfg = 32'h0000_4400;
		for (n = 0; n < 40; n++)
			sx(lfsr[9:0], lfsr[15:6], lfsr[9:0] ^ 10'h200, lfsr[15:6] ^ 10'h200);
		drain();
		doReset();
		dataPathCfg = 32'h0000_0402;
		for (n = 0; n < 15; n++)
			sx((n == 0) ? 10'h100 : 10'h000, (n == 0) ? 10'h100 : 10'h000,
				10'(coef[n]), 10'(coef[n]));
		drain();
		for (int c = 1; c < 8; c++)
		begin
			int m;
			m = (c > 5) ? 5 : c;
			doReset();
			dataPathCfg = 32'(32'h400 | (c << 2) | ((m - 1) << 5));
			expQ.push_back({10'h008, 10'h3f8});
			repeat (3) expQ.push_back({10'h010, 10'h3f0});
			repeat (4 << (m - 1)) u_tun.send(10'h008, 10'h3f8);
			drain();
		end
		for (n = 0; n < 6; n++)
		begin
			loopUpper = 32'(lpU[n]);
			loopLower = 32'(lpL[n]);
			loopLead = 32'(lpD[n]);
			loopLag = 32'(lpG[n]);
			loopCtl1 = 8'(lpC[n]);
			loopUpdate = 1'b1;
			@(negedge clk);
			check(carrierFreqWord, 32'(lpW[n]));
			check(extNcoWord, 32'(lpE[n]));
		end
		loopUpdate = 1'b0;
		finishTest();
	end
endmodule
